//--- rtl/sfm_consts.svh
// constants for the serial fault monitor and pin control block
`ifndef SFM_CONSTS_SVH
`define SFM_CONSTS_SVH
`define SFM_NUM_PINS      5
`define SFM_PIN_SIMO      0
`define SFM_PIN_SOMI      1
`define SFM_PIN_CLK       2
`define SFM_PIN_READY     3
`define SFM_PIN_SELECT    4
`define SFM_NUM_FORMATS   4
`define SFM_DIV_W         8
`define SFM_DLY_W         8
`define SFM_LEN_W         5
`define SFM_DIV_EXTRA     8'h02
`define SFM_DEF_CHAR_LEN  5'h08
`define SFM_DEF_DIVIDER   8'h00
`define SFM_PIN_RESET     5'h00
`endif

//--- rtl/sfm_core.sv
// serial controller fault monitor, reset, sleep and pin control
// ----------------------------------------------------------
// Functional notes
// - master in enable or five-pin mode watches the ready handshake
// - ready released mid-character flags sync loss
// - eight-bit release timeout loaded from the delay configuration
// - sync loss sets buffer bit and flag, interrupt if enabled
// - release window starts after deselect delay, or after shifting
// - ready sampled every divider plus two clocks; release ends window
// - full release window is timeout plus divider plus two clocks
// - release window runs only if ready high, timeout nonzero, wait set
// - response window starts after select delay, or at select
// - no ready in time sets timeout bit, flag, interrupt, aborts
// - response window ends on ready seen in any clock, else value plus divider plus two
// - response window needs ready low and wait bit; zero waits forever
// - master flags length error on early ready release if pin functional
// - slave flags length error on early deselect if pin functional
// - soft reset bit low or hardware reset restores all defaults
// - sleep bit freezes internal logic and registers
// - register access while asleep runs clock for that access only
// - pins functional or general purpose with direction and level
// - set and clear writes change only the bits written with one
// - pin input shows live level for inputs, driven value for outputs
// - debug halt ignored; reads of status clear even from debugger
// - four formats hold the divider, chosen per transfer
// ----------------------------------------------------------
module sfm_core
    import sfm_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    input  wire logic                soft_reset_release,
    input  wire logic                local_sleep_bit,
    input  wire logic                reg_access,
    input  wire logic                master_mode,
    input  wire logic                debug_halt,
    input  wire logic                fmt_we,
    input  wire logic [1:0]          fmt_waddr,
    input  wire sfm_pkg::sfm_fmt_t   fmt_wdata,
    input  wire logic                delay_we,
    input  wire sfm_pkg::sfm_dly_t   select_to_shift_delay,
    input  wire sfm_pkg::sfm_dly_t   end_to_deselect_delay,
    input  wire sfm_pkg::sfm_dly_t   select_to_response_timeout,
    input  wire sfm_pkg::sfm_dly_t   end_to_release_timeout,
    input  wire logic                tx_start,
    input  wire logic [1:0]          tx_format_select,
    output logic                     tx_ready,
    input  wire logic                shift_bit_tick,
    input  wire logic                sync_loss_ie,
    input  wire logic                timeout_ie,
    input  wire logic                length_ie,
    input  wire logic                buffer_read,
    input  wire logic                flag_read,
    input  wire logic                func_we,
    input  wire logic                dir_we,
    input  wire logic                out_we,
    input  wire logic                set_we,
    input  wire logic                clr_we,
    input  wire sfm_pkg::sfm_pins_t  pin_wdata,
    input  wire sfm_pkg::sfm_pins_t  pin_in,
    output sfm_pkg::sfm_pins_t       pin_out,
    output sfm_pkg::sfm_pins_t       pin_oe,
    output sfm_pkg::sfm_pins_t       pin_function_reg,
    output sfm_pkg::sfm_pins_t       pin_direction_reg,
    output sfm_pkg::sfm_pins_t       pin_output_reg,
    output sfm_pkg::sfm_pins_t       pin_input_reg,
    output logic                     sync_loss_bit,
    output logic                     timeout_bit,
    output logic                     sync_loss_flag,
    output logic                     response_expired_flag,
    output logic                     length_error_flag,
    output logic                     fault_irq,
    output sfm_pkg::sfm_state_t      shift_state,
    output logic                     sleeping
);
    import sfm_pkg::*;

    // ----------------------------------------------------------
    // clock gating and reset
    // ----------------------------------------------------------
    logic run;
    logic rst_n;
    logic acc_en;
    assign rst_n  = reset_n && soft_reset_release;
    // debug_halt intentionally has no effect
    assign run    = clk_en && !local_sleep_bit;
    assign acc_en = clk_en && (!local_sleep_bit || reg_access);
    assign sleeping = local_sleep_bit;

    // ----------------------------------------------------------
    // formats and delays
    // ----------------------------------------------------------
    sfm_fmt_t fmt [`SFM_NUM_FORMATS];
    sfm_fmt_t cur_fmt, win_fmt;
    logic [1:0] fmt_sel;
    sfm_dly_t c2t, t2c, c2e, t2e;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < `SFM_NUM_FORMATS; i++) begin
                fmt[i] <= '{`SFM_DEF_DIVIDER, `SFM_DEF_CHAR_LEN, 1'b0};
            end
        end else if (acc_en && fmt_we) begin
            fmt[fmt_waddr] <= fmt_wdata;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            c2t <= '0;
            t2c <= '0;
            c2e <= '0;
            t2e <= '0;
        end else if (acc_en && delay_we) begin
            c2t <= select_to_shift_delay;
            t2c <= end_to_deselect_delay;
            c2e <= select_to_response_timeout;
            t2e <= end_to_release_timeout;
        end
    end
    assign cur_fmt = fmt[fmt_sel];
    assign win_fmt = (state == SFM_IDLE) ? fmt[tx_format_select] : cur_fmt;

    // ----------------------------------------------------------
    // sample ticker
    // ----------------------------------------------------------
    sfm_sample_if smp ();
    logic win_start;
    assign smp.divider = cur_fmt.divider;
    assign smp.restart = win_start;
    sfm_ticker u_ticker (
        .clk_sys (clk_sys),
        .reset_n (rst_n),
        .clk_en  (run),
        .smp     (smp)
    );

    // ----------------------------------------------------------
    // pin control
    // ----------------------------------------------------------
    sfm_pins_t func_out;
    sfm_pins_t func_oe;
    logic      select_drive;
    sfm_gpio u_gpio (
        .clk_sys           (clk_sys),
        .reset_n           (rst_n),
        .clk_en            (acc_en),
        .func_we           (func_we),
        .func_wdata        (pin_wdata),
        .dir_we            (dir_we),
        .dir_wdata         (pin_wdata),
        .out_we            (out_we),
        .out_wdata         (pin_wdata),
        .set_we            (set_we),
        .clr_we            (clr_we),
        .mask_wdata        (pin_wdata),
        .func_out          (func_out),
        .func_oe           (func_oe),
        .pin_in            (pin_in),
        .pin_function_reg  (pin_function_reg),
        .pin_direction_reg (pin_direction_reg),
        .pin_output_reg    (pin_output_reg),
        .pin_input_reg     (pin_input_reg),
        .pin_out           (pin_out),
        .pin_oe            (pin_oe)
    );
    always_comb begin
        func_out = '0;
        func_oe  = '0;
        func_out[`SFM_PIN_SELECT] = !select_drive;
        func_oe[`SFM_PIN_SELECT]  = master_mode;
    end

    // ----------------------------------------------------------
    // handshake view
    // ----------------------------------------------------------
    logic ready_used;
    logic select_used;
    logic ready_in;
    logic select_in;
    assign ready_used  = pin_function_reg[`SFM_PIN_READY];
    assign select_used = pin_function_reg[`SFM_PIN_SELECT];
    assign ready_in    = !pin_in[`SFM_PIN_READY];
    assign select_in   = !pin_in[`SFM_PIN_SELECT];

    // ----------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------
    sfm_state_t state;
    sfm_state_t next_state;
    sfm_dly_t   win_cnt;
    sfm_len_t   bit_cnt;
    logic       win_active;
    logic       ev_sync_loss_bit;
    logic       ev_timeout;
    logic       ev_length;
    logic       bits_done;
    logic       five_pin;
    assign shift_state = state;
    assign tx_ready    = (state == SFM_IDLE) && master_mode;
    assign five_pin    = ready_used && select_used;
    assign bits_done   = (bit_cnt + 5'h01) >= cur_fmt.char_len;
    assign select_drive = master_mode && (state != SFM_IDLE) && (state != SFM_RELEASE);

    always_comb begin
        next_state = state;
        win_start  = 1'b0;
        ev_sync_loss_bit  = 1'b0;
        ev_timeout = 1'b0;
        ev_length  = 1'b0;
        unique case (state)
            SFM_IDLE: begin
                if (tx_start && master_mode) begin
                    next_state = (c2t != 8'h00) ? SFM_SEL_DLY : SFM_RESP;
                    win_start  = 1'b1;
                end
            end
            SFM_SEL_DLY: begin
                if (win_cnt == 8'h00) begin
                    next_state = SFM_RESP;
                    win_start  = 1'b1;
                end
            end
            SFM_RESP: begin
                if (!five_pin || !cur_fmt.wait_for_ready_bit || ready_in) begin
                    next_state = SFM_SHIFT;
                end else if (win_active && win_cnt == 8'h00 && smp.tick && !ready_in) begin
                    ev_timeout = 1'b1;
                    next_state = SFM_IDLE;
                end
            end
            SFM_SHIFT: begin
                if (ready_used && ready_prev && !ready_in) begin
                    ev_sync_loss_bit  = 1'b1;
                    ev_length  = 1'b1;
                    next_state = SFM_IDLE;
                end else if (shift_bit_tick && bits_done) begin
                    next_state = (t2c != 8'h00) ? SFM_DESEL : SFM_RELEASE;
                    win_start  = 1'b1;
                end
            end
            SFM_DESEL: begin
                if (win_cnt == 8'h00) begin
                    next_state = SFM_RELEASE;
                    win_start  = 1'b1;
                end
            end
            SFM_RELEASE: begin
                if (!win_active || (smp.tick && !ready_in)) begin
                    next_state = SFM_IDLE;
                end else if (win_cnt == 8'h00 && smp.tick) begin
                    ev_sync_loss_bit  = 1'b1;
                    next_state = SFM_IDLE;
                end
            end
            default: next_state = SFM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= SFM_IDLE;
        end else if (run) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fmt_sel <= 2'h0;
        end else if (run && state == SFM_IDLE && tx_start) begin
            fmt_sel <= tx_format_select;
        end
    end

    // window counter: delay phases count clocks, timeout phases count down
    // and expire on the first sample after zero, giving value plus divider plus two
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            win_cnt    <= '0;
            win_active <= 1'b0;
        end else if (run) begin
            if (win_start) begin
                unique case (next_state)
                    SFM_SEL_DLY: begin
                        win_cnt    <= c2t;
                        win_active <= 1'b0;
                    end
                    SFM_DESEL: begin
                        win_cnt    <= t2c;
                        win_active <= 1'b0;
                    end
                    SFM_RESP: begin
                        win_cnt    <= c2e;
                        win_active <= five_pin && win_fmt.wait_for_ready_bit
                                      && !ready_in && (c2e != 8'h00);
                    end
                    SFM_RELEASE: begin
                        win_cnt    <= t2e;
                        win_active <= ready_used && cur_fmt.wait_for_ready_bit
                                      && ready_in && (t2e != 8'h00);
                    end
                    default: begin
                        win_cnt    <= '0;
                        win_active <= 1'b0;
                    end
                endcase
            end else if (win_cnt != 8'h00) begin
                win_cnt <= win_cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bit_cnt <= '0;
        end else if (run) begin
            if (state != SFM_SHIFT && !(!master_mode && select_in)) begin
                bit_cnt <= '0;
            end else if (shift_bit_tick) begin
                bit_cnt <= bits_done ? 5'h00 : bit_cnt + 5'h01;
            end
        end
    end

    // slave: deselect seen before the counter wraps
    logic select_prev, ready_prev;
    logic slave_len_err;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            select_prev <= 1'b0;
            ready_prev  <= 1'b0;
        end else if (run) begin
            select_prev <= select_in;
            ready_prev  <= ready_in;
        end
    end
    assign slave_len_err = !master_mode && select_used && select_prev && !select_in
                           && (bit_cnt != 5'h00);

    // ----------------------------------------------------------
    // status bits and flags; set wins over read clear
    // ----------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_loss_bit <= 1'b0;
            timeout_bit   <= 1'b0;
        end else if (acc_en) begin
            sync_loss_bit <= (run && ev_sync_loss_bit) || (sync_loss_bit && !buffer_read);
            timeout_bit   <= (run && ev_timeout) || (timeout_bit && !buffer_read);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_loss_flag        <= 1'b0;
            response_expired_flag <= 1'b0;
            length_error_flag     <= 1'b0;
        end else if (acc_en) begin
            sync_loss_flag        <= (run && ev_sync_loss_bit) || (sync_loss_flag && !flag_read);
            response_expired_flag <= (run && ev_timeout)
                                     || (response_expired_flag && !flag_read);
            length_error_flag     <= (run && (ev_length || slave_len_err))
                                     || (length_error_flag && !flag_read);
        end
    end
    assign fault_irq = (sync_loss_flag && sync_loss_ie)
                       || (response_expired_flag && timeout_ie)
                       || (length_error_flag && length_ie);
endmodule

//--- rtl/sfm_gpio.sv
// pin function, direction and output level control
module sfm_gpio
    import sfm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        func_we,
    input  wire sfm_pins_t   func_wdata,
    input  wire logic        dir_we,
    input  wire sfm_pins_t   dir_wdata,
    input  wire logic        out_we,
    input  wire sfm_pins_t   out_wdata,
    input  wire logic        set_we,
    input  wire logic        clr_we,
    input  wire sfm_pins_t   mask_wdata,
    input  wire sfm_pins_t   func_out,
    input  wire sfm_pins_t   func_oe,
    input  wire sfm_pins_t   pin_in,
    output sfm_pins_t        pin_function_reg,
    output sfm_pins_t        pin_direction_reg,
    output sfm_pins_t        pin_output_reg,
    output sfm_pins_t        pin_input_reg,
    output sfm_pins_t        pin_out,
    output sfm_pins_t        pin_oe
);
    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_function_reg  <= `SFM_PIN_RESET;
            pin_direction_reg <= `SFM_PIN_RESET;
        end else if (clk_en) begin
            if (func_we) begin
                pin_function_reg <= func_wdata;
            end
            if (dir_we) begin
                pin_direction_reg <= dir_wdata;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_output_reg <= `SFM_PIN_RESET;
        end else if (clk_en) begin
            if (out_we) begin
                pin_output_reg <= out_wdata;
            end else if (set_we) begin
                pin_output_reg <= pin_output_reg | mask_wdata;
            end else if (clr_we) begin
                pin_output_reg <= pin_output_reg & ~mask_wdata;
            end
        end
    end
    // ----------------------------------------------------------
    // pin muxing
    // ----------------------------------------------------------
    always_comb begin
        for (int i = 0; i < `SFM_NUM_PINS; i++) begin
            pin_out[i] = pin_function_reg[i] ? func_out[i] : pin_output_reg[i];
            pin_oe[i]  = pin_function_reg[i] ? func_oe[i] : pin_direction_reg[i];
            pin_input_reg[i] = pin_oe[i] ? pin_out[i] : pin_in[i];
        end
    end
endmodule

//--- rtl/sfm_pkg.sv
// types shared by the serial fault monitor modules
`include "sfm_consts.svh"
package sfm_pkg;
    typedef logic [`SFM_NUM_PINS-1:0] sfm_pins_t;
    typedef logic [`SFM_DIV_W-1:0]    sfm_div_t;
    typedef logic [`SFM_DLY_W-1:0]    sfm_dly_t;
    typedef logic [`SFM_LEN_W-1:0]    sfm_len_t;
    typedef struct packed {
        sfm_div_t divider;
        sfm_len_t char_len;
        logic     wait_for_ready_bit;
    } sfm_fmt_t;
    typedef enum logic [2:0] {
        SFM_IDLE     = 3'b000,
        SFM_SEL_DLY  = 3'b001,
        SFM_RESP     = 3'b010,
        SFM_SHIFT    = 3'b011,
        SFM_DESEL    = 3'b100,
        SFM_RELEASE  = 3'b101
    } sfm_state_t;
endpackage

//--- rtl/sfm_sample_if.sv
// sample tick carrier between the main block and its ticker
interface sfm_sample_if;
    import sfm_pkg::*;
    sfm_div_t divider;
    logic     restart;
    logic     tick;
    modport owner  (output divider, output restart, input tick);
    modport ticker (input divider, input restart, output tick);
endinterface

//--- rtl/sfm_ticker.sv
// sampling ticker: one pulse every divider plus two clocks, none for a full-scale divider
module sfm_ticker
    import sfm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    sfm_sample_if.ticker     smp
);
    sfm_div_t count;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count <= '0;
        end else if (clk_en) begin
            if (smp.restart || smp.tick) begin
                count <= '0;
            end else begin
                count <= count + 8'h01;
            end
        end
    end
    // compare widened, so a full-scale divider never matches the count and no tick is made
    assign smp.tick = ({1'b0, count} == ({1'b0, smp.divider} + 9'h001)) && !smp.restart;
endmodule

//--- test/sfm_core_bench.sv
// self-checking bench for the serial fault monitor core
module sfm_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfm_pkg::*;
    typedef struct packed {
        logic [1:0] mode; logic [7:0] delay; logic [1:0] fmt; logic [2:0] exp;
    } sfm_row_t;
    logic clk_sys, reset_n, clk_en, soft_reset_release, local_sleep_bit, reg_access, master_mode;
    logic debug_halt, fmt_we, delay_we, tx_start, tx_ready, shift_bit_tick, sync_loss_ie, ready_n;
    logic timeout_ie, length_ie, buffer_read, flag_read, sleeping, fault_irq, func_we, dir_we;
    logic out_we, set_we, clr_we, sync_loss_bit, timeout_bit, sync_loss_flag;
    logic response_expired_flag, length_error_flag;
    logic [1:0] fmt_waddr, tx_format_select, mode;
    logic [7:0] resp_delay;
    sfm_fmt_t   fmt_wdata;
    sfm_dly_t   select_to_shift_delay, end_to_deselect_delay, select_to_response_timeout;
    sfm_dly_t   end_to_release_timeout;
    sfm_pins_t  pin_wdata, pin_in, pin_out, pin_oe, pin_function_reg, pin_direction_reg;
    sfm_pins_t  pin_output_reg, pin_input_reg;
    sfm_state_t shift_state;
    int         fails, tests_run;
    sfm_row_t   rows [7] = '{'{2'h0, 8'h01, 2'h0, 3'h0}, '{2'h0, 8'h05, 2'h1, 3'h0},
        '{2'h0, 8'h28, 2'h0, 3'h2}, '{2'h0, 8'h28, 2'h1, 3'h2}, '{2'h2, 8'h01, 2'h0, 3'h5},
        '{2'h3, 8'h01, 2'h0, 3'h4}, '{2'h3, 8'h01, 2'h2, 3'h0}};
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {1'b1, ready_n, 3'h5});
    sfm_slave_model partner (.clk_sys, .select_n(pin_in[4]), .bit_tick(shift_bit_tick), .mode,
        .resp_delay, .ready_n);
    sfm_core uut (.*);
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp) fails++;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [4:0] sel, input sfm_pins_t d);
        pin_wdata = d;
        {reg_access, func_we, dir_we, out_we, set_we, clr_we} = {1'b1, sel};
        @(negedge clk_sys);
        {reg_access, func_we, dir_we, out_we, set_we, clr_we} = 6'h00;
        @(negedge clk_sys);
    endtask
    task automatic run_row(input sfm_row_t r);
        int n;
        int bits;
        {mode, resp_delay, tx_format_select, tx_start} = {r.mode, r.delay, r.fmt, 1'b1};
        @(negedge clk_sys);
        tx_start = 1'b0;
        bits = 0;
        for (n = 0; n < 400 && shift_state != SFM_IDLE; n++) begin
            shift_bit_tick = shift_state == SFM_SHIFT && n % 4 == 0 && bits < 8;
            bits += shift_bit_tick;
            @(negedge clk_sys);
        end
        shift_bit_tick = 1'b0;
        @(negedge clk_sys);
        cmp({5'h00, sync_loss_flag, response_expired_flag, length_error_flag}, {5'h00, r.exp});
        cmp({sync_loss_bit, timeout_bit, fault_irq}, {r.exp[2:1], |r.exp});
        cmp({shift_state == SFM_IDLE, pin_out[4]}, 8'h03);
        {mode, reg_access, buffer_read, flag_read} = 5'h07;
        @(negedge clk_sys);
        {reg_access, buffer_read, flag_read} = 3'h0;
        @(negedge clk_sys);
        cmp({sync_loss_flag, timeout_bit, fault_irq}, 8'h00);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        fails++;
        report_and_stop;
    end
    initial begin
        {clk_en, soft_reset_release, master_mode, debug_halt, reset_n, local_sleep_bit} = 6'h3C;
        {reg_access, fmt_we, delay_we, tx_start, shift_bit_tick, buffer_read, flag_read} = 7'h00;
        {func_we, dir_we, out_we, set_we, clr_we, fmt_waddr, tx_format_select, mode} = 11'h000;
        {sync_loss_ie, timeout_ie, length_ie, resp_delay, fmt_wdata, pin_wdata} = {3'h7, 27'h0};
        {select_to_shift_delay, end_to_deselect_delay, select_to_response_timeout} = 24'h00000A;
        end_to_release_timeout = 8'h06;
        fails = 0;
        tests_run = 0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        cmp({pin_function_reg, sync_loss_flag, timeout_bit, length_error_flag}, 8'h00);
        wr(5'h08, 5'h13);
        wr(5'h04, 5'h01);
        wr(5'h02, 5'h12);
        wr(5'h01, 5'h03);
        cmp({3'h0, pin_output_reg}, 8'h10);
        cmp({3'h0, pin_oe}, 8'h13);
        cmp({3'h0, pin_input_reg}, 8'h1C);
        wr(5'h10, 5'h1F);
        for (int i = 0; i < 3; i++) begin
            {fmt_wdata, fmt_waddr} = {(i == 1) ? 8'h03 : 8'h00, 5'h08, i != 2, i[1:0]};
            {fmt_we, delay_we, reg_access} = 3'h7;
            @(negedge clk_sys);
            {fmt_we, delay_we, reg_access} = 3'h0;
            @(negedge clk_sys);
        end
        foreach (rows[k]) run_row(rows[k]);
        {local_sleep_bit, tx_start} = 2'h3;
        @(negedge clk_sys);
        tx_start = 1'b0;
        wr(5'h02, 5'h01);
        cmp({shift_state == SFM_IDLE, sleeping}, 8'h03);
        cmp({3'h0, pin_output_reg}, 8'h11);
        {local_sleep_bit, soft_reset_release} = 2'h0;
        @(negedge clk_sys);
        soft_reset_release = 1'b1;
        cmp({3'h0, pin_function_reg | pin_output_reg | pin_direction_reg}, 8'h00);
        report_and_stop;
    end
endmodule
bind sfm_core sfm_core_chk chk (.*);

//--- test/sfm_core_chk.sv
// assertion checker for the serial fault monitor core
module sfm_core_chk
    import sfm_pkg::*;
(
    input logic       clk_sys,
    input logic       reset_n,
    input logic       clk_en,
    input logic       soft_reset_release,
    input logic       local_sleep_bit,
    input logic       reg_access,
    input logic       tx_start,
    input logic       tx_ready,
    input logic       out_we,
    input logic       set_we,
    input logic       clr_we,
    input logic       sync_loss_flag,
    input logic       response_expired_flag,
    input sfm_pins_t  pin_wdata,
    input sfm_pins_t  pin_in,
    input sfm_pins_t  pin_out,
    input sfm_pins_t  pin_oe,
    input sfm_pins_t  pin_function_reg,
    input sfm_pins_t  pin_direction_reg,
    input sfm_pins_t  pin_output_reg,
    input sfm_pins_t  pin_input_reg,
    input sfm_state_t shift_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_ok;
    assign wr_ok = reg_access && clk_en && soft_reset_release && !out_we;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence s_accept;
        tx_start && tx_ready && clk_en && soft_reset_release && !local_sleep_bit;
    endsequence
    sequence s_asleep;
        local_sleep_bit && !reg_access && soft_reset_release;
    endsequence
    a_start_leaves_idle: assert property (s_accept |=> shift_state != SFM_IDLE)
        else $error("start not taken");
    a_sleep_freezes: assert property (s_asleep |=> $stable(shift_state) &&
        $stable(sync_loss_flag) && $stable(response_expired_flag)) else $error("moved asleep");
    a_set_bits: assert property (set_we && wr_ok |=>
        (pin_output_reg & $past(pin_wdata)) == $past(pin_wdata)) else $error("set lost");
    a_clear_bits: assert property (clr_we && !set_we && wr_ok |=>
        pin_output_reg == ($past(pin_output_reg) & ~$past(pin_wdata))) else $error("clear bad");
    a_gpio_dir: assert property ((~pin_function_reg & pin_oe) ==
        (~pin_function_reg & pin_direction_reg)) else $error("gpio direction");
    a_gpio_level: assert property ((~pin_function_reg & pin_oe & pin_out) ==
        (~pin_function_reg & pin_oe & pin_output_reg)) else $error("gpio level");
    a_pin_readback: assert property (pin_input_reg ==
        ((pin_oe & pin_out) | (~pin_oe & pin_in))) else $error("pin readback");
    a_soft_reset: assert property (clk_en && !soft_reset_release |=>
        shift_state == SFM_IDLE && pin_function_reg == 5'h00 && !sync_loss_flag)
        else $error("soft reset");
endmodule

//--- test/sfm_slave_model.sv
// far-side slave driving the active-low ready handshake
module sfm_slave_model (
    input  logic       clk_sys,
    input  logic       select_n,
    input  logic       bit_tick,
    input  logic [1:0] mode,
    input  logic [7:0] resp_delay,
    output logic       ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lag = 8'h00;
    logic [3:0] bits = 4'h0;
    initial ready_n = 1'b1;
    // mode 2 lets go mid-character, mode 3 never lets go
    always @(posedge clk_sys) begin
        lag <= select_n ? 8'h00 : lag + 8'h01;
        bits <= select_n ? 4'h0 : bits + {3'h0, bit_tick};
        if (select_n && mode != 2'h3) begin
            ready_n <= 1'b1;
        end else if (!select_n && lag == resp_delay) begin
            ready_n <= 1'b0;
        end else if (bits == (mode == 2'h2 ? 4'h5 : 4'h8) && mode != 2'h3) begin
            ready_n <= 1'b1;
        end
    end
endmodule
